/* pkg/vin_pkg.sv */
// Purpose: Shared constants for the voltage input telegram block
// Assumes: 50 MHz system clock
// Notes:   Register offsets are byte addresses on a 16-bit port
`default_nettype none
package vin_pkg;
  // ==========================================
  // Timing
  localparam int unsigned CLK_HZ    = 50_000_000;
  localparam int unsigned MEAS_MS   = 100;
  localparam int unsigned MEAS_CYC  = MEAS_MS * (CLK_HZ / 1000);
  localparam int unsigned TX_US     = 6500;
  localparam int unsigned TX_CYC    = TX_US * (CLK_HZ / 1_000_000);
  localparam int unsigned MAINS_SMP = 16;
  localparam int unsigned M50_HZ    = 50;
  localparam int unsigned M60_HZ    = 60;
  localparam int unsigned M50_CYC   = CLK_HZ / (M50_HZ * MAINS_SMP);
  localparam int unsigned M60_CYC   = CLK_HZ / (M60_HZ * MAINS_SMP);
  localparam int unsigned TMR_W     = 24;
  localparam logic [TMR_W-1:0] TMR_ONE = 24'h000001;
  localparam int unsigned SMP_SH    = 4;
  // ==========================================
  // Telegram and identity
  localparam logic [7:0]  CFG_CODE_V = 8'h32;
  localparam logic [3:0]  IN_BYTES   = 4'h2;
  localparam logic [3:0]  OUT_BYTES  = 4'h0;
  localparam logic [15:0] START_DEF  = 16'h2710;
  localparam logic [15:0] END_DEF    = 16'hC350;
  localparam logic signed [15:0] PCT_MIN = 16'hF63C;
  localparam logic signed [15:0] PCT_MAX = 16'h30D4;
  // Reciprocal of 10000 and ramp step per 6.5 ms tick, fixed point
  localparam int unsigned PCT_K  = 6711;
  localparam int unsigned PCT_SH = 26;
  localparam int unsigned RAMP_K  = 279173;
  localparam int unsigned RAMP_SH = 32;
  // ==========================================
  // Register map
  localparam logic [5:0] A_CTRL  = 6'h00;
  localparam logic [5:0] A_START = 6'h04;
  localparam logic [5:0] A_END   = 6'h08;
  localparam logic [5:0] A_SUBST = 6'h0C;
  localparam logic [5:0] A_SIM   = 6'h10;
  localparam logic [5:0] A_RAMP  = 6'h14;
  localparam logic [5:0] A_STAT  = 6'h18;
  localparam logic [5:0] A_VALUE = 6'h1C;
  localparam logic [5:0] A_CFG   = 6'h20;
  localparam int unsigned C_SIM = 0;
  localparam int unsigned C_ERR = 1;
  localparam int unsigned C_STS = 3;
  localparam int unsigned C_M60 = 4;
  localparam int unsigned C_REP = 5;
  localparam logic [1:0] ERR_CUR  = 2'h0;
  localparam logic [1:0] ERR_SUB  = 2'h1;
  localparam logic [1:0] ERR_LAST = 2'h2;
  typedef enum logic [1:0] {TX_IDLE, TX_LO, TX_HI} vin_tx_e;
endpackage
`default_nettype wire

/* pkg/vin_flt_if.sv */
// Purpose: Carries the scaled value into the ramp filter and back
// Assumes: Both ends on the same clock
// Notes:   No clocking; plain wires
`default_nettype none
interface vin_flt_if;
  logic [15:0] raw;
  logic        step;
  logic [7:0]  rate;
  logic [15:0] span;
  logic [15:0] filt;
  modport ctl (output raw, step, rate, span, input filt);
  modport flt (input raw, step, rate, span, output filt);
endinterface
`default_nettype wire

/* core/vin_tick.sv */
// Purpose: Free running period timer, one-cycle tick
// Assumes: period of at least 2
// Notes:   Period may change on the fly
`default_nettype none
module vin_tick (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic [vin_pkg::TMR_W-1:0] period,
  output var  logic                      tick
);
  logic [vin_pkg::TMR_W-1:0] cnt_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= '0;
      tick   <= 1'b0;
    end else if (cnt_ff >= period - vin_pkg::TMR_ONE) begin
      cnt_ff <= '0;
      tick   <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + vin_pkg::TMR_ONE;
      tick   <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* core/vin_ramp.sv */
// Purpose: Linear ramp limiter on the scaled value
// Assumes: step comes once per telegram period
// Notes:   Rate zero passes the value straight through
`default_nettype none
module vin_ramp (
  input  wire logic clk,
  input  wire logic rst,
  vin_flt_if.flt    f
);
  logic [42:0] prod;
  logic [15:0] dlt;

  always_comb begin
    prod = 43'(f.rate) * 43'(f.span) * 43'(vin_pkg::RAMP_K);
    dlt  = 16'(prod >> vin_pkg::RAMP_SH);
    // Never stall completely on a small span
    if (dlt == 16'h0000) begin
      dlt = 16'h0001;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      f.filt <= 16'h0000;
    end else if (f.step) begin
      if (f.rate == 8'h00) begin
        f.filt <= f.raw;
      end else if (f.raw > f.filt) begin
        f.filt <= (f.raw - f.filt > dlt) ? f.filt + dlt : f.raw;
      end else begin
        f.filt <= (f.filt - f.raw > dlt) ? f.filt - dlt : f.raw;
      end
    end
  end

  ramp_off_a: assert property (@(posedge clk) disable iff (rst)
    f.step && f.rate == 8'h00 |=> f.filt == $past(f.raw))
    else $error("ramp off did not pass value");
  ramp_lim_a: assert property (@(posedge clk) disable iff (rst)
    f.step && f.raw > f.filt |=> f.filt > $past(f.filt) && f.filt <= $past(f.raw))
    else $error("ramp moved wrong way");
endmodule
`default_nettype wire

/* core/vin_top.sv */
// Purpose: Voltage input channel, scaling, modes and 2-byte telegram
// Assumes: ADC_DATA and MEAS_FAULT synchronous to CLOCK
// Notes:   Telegram bytes leave low byte first, one per cycle
`default_nettype none
module vin_top #(
  parameter int unsigned MEAS_CYC = vin_pkg::MEAS_CYC,
  parameter int unsigned TX_CYC   = vin_pkg::TX_CYC,
  parameter int unsigned M50_CYC  = vin_pkg::M50_CYC,
  parameter int unsigned M60_CYC  = vin_pkg::M60_CYC
) (
  input  wire logic        CLOCK,
  input  wire logic        RST,
  input  wire logic [5:0]  REG_ADDR,
  input  wire logic [15:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output var  logic [15:0] REG_RDATA,
  input  wire logic [15:0] ADC_DATA,
  input  wire logic        MEAS_FAULT,
  output var  logic [7:0]  TX_BYTE,
  output var  logic        TX_VALID,
  output var  logic        TX_FIRST,
  output var  logic [7:0]  CFG_CODE,
  output var  logic [3:0]  CFG_IN_BYTES,
  output var  logic [3:0]  CFG_OUT_BYTES,
  output var  logic        MOD_ERR,
  output var  logic        GLOB_ERR,
  output var  logic        LEAD_BREAK,
  output var  logic        SHORT_CIRC
);
  // ==========================================
  // Helpers
  function automatic logic [15:0] pct_to_val(
    input logic [15:0] pct,
    input logic [15:0] st,
    input logic [15:0] sp
  );
    logic signed [15:0] p;
    logic signed [47:0] prod;
    logic signed [47:0] v;
    p = signed'(pct);
    if (p < vin_pkg::PCT_MIN) begin
      p = vin_pkg::PCT_MIN;
    end else if (p > vin_pkg::PCT_MAX) begin
      p = vin_pkg::PCT_MAX;
    end
    prod = 48'(p) * signed'(48'(sp)) * signed'(48'(vin_pkg::PCT_K));
    v = signed'(48'(st)) + (prod >>> vin_pkg::PCT_SH);
    // Clamp into the unsigned telegram range
    if (v < 0) begin
      v = '0;
    end else if (v > signed'(48'(16'hFFFF))) begin
      v = signed'(48'(16'hFFFF));
    end
    return v[15:0];
  endfunction

  // ==========================================
  // Registers
  logic [5:0]  ctrl_ff;
  logic [15:0] start_ff;
  logic [15:0] end_ff;
  logic [15:0] subst_ff;
  logic [15:0] sim_ff;
  logic [7:0]  rate_ff;

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      ctrl_ff  <= 6'h00;
      start_ff <= vin_pkg::START_DEF;
      end_ff   <= vin_pkg::END_DEF;
      subst_ff <= 16'h0000;
      sim_ff   <= 16'h0000;
      rate_ff  <= 8'h00;
    end else if (REG_WR) begin
      case (REG_ADDR)
        vin_pkg::A_CTRL:  ctrl_ff  <= REG_WDATA[5:0];
        vin_pkg::A_START: start_ff <= REG_WDATA;
        vin_pkg::A_END:   end_ff   <= REG_WDATA;
        vin_pkg::A_SUBST: subst_ff <= REG_WDATA;
        vin_pkg::A_SIM:   sim_ff   <= REG_WDATA;
        vin_pkg::A_RAMP:  rate_ff  <= REG_WDATA[7:0];
        default: ;
      endcase
    end
  end

  logic       sim_mode;
  logic [1:0] err_mode;
  logic       sts_req;
  logic       rep_en;
  assign sim_mode = ctrl_ff[vin_pkg::C_SIM];
  assign err_mode = ctrl_ff[vin_pkg::C_ERR +: 2];
  assign sts_req  = ctrl_ff[vin_pkg::C_STS];
  assign rep_en   = ctrl_ff[vin_pkg::C_REP];

  // ==========================================
  // Timers
  logic                      smp_tick;
  logic                      meas_tick;
  logic                      tx_tick;
  logic [vin_pkg::TMR_W-1:0] smp_per;

  assign smp_per = ctrl_ff[vin_pkg::C_M60] ? vin_pkg::TMR_W'(M60_CYC)
                                           : vin_pkg::TMR_W'(M50_CYC);

  vin_tick u_smp (
    .clk    (CLOCK),
    .rst    (RST),
    .period (smp_per),
    .tick   (smp_tick)
  );
  vin_tick u_meas (
    .clk    (CLOCK),
    .rst    (RST),
    .period (vin_pkg::TMR_W'(MEAS_CYC)),
    .tick   (meas_tick)
  );
  vin_tick u_tx (
    .clk    (CLOCK),
    .rst    (RST),
    .period (vin_pkg::TMR_W'(TX_CYC)),
    .tick   (tx_tick)
  );

  // ==========================================
  // Mains rejection: average 16 samples over one mains period
  logic [19:0] acc_ff;
  logic [3:0]  nsmp_ff;
  logic [15:0] avg_ff;
  logic [19:0] acc_sum;
  assign acc_sum = acc_ff + 20'(ADC_DATA);

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      acc_ff  <= 20'h00000;
      nsmp_ff <= 4'h0;
      avg_ff  <= 16'h0000;
    end else if (smp_tick) begin
      nsmp_ff <= nsmp_ff + 4'h1;
      if (nsmp_ff == 4'hF) begin
        avg_ff <= 16'(acc_sum >> vin_pkg::SMP_SH);
        acc_ff <= 20'h00000;
      end else begin
        acc_ff <= acc_sum;
      end
    end
  end

  // ==========================================
  // Measurement and scaling
  logic [15:0] span;
  logic [31:0] scl_prod;
  logic [15:0] meas_ff;
  logic        mvld_ff;
  assign span     = (end_ff > start_ff) ? end_ff - start_ff : 16'h0000;
  assign scl_prod = 32'(avg_ff) * 32'(span);

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      meas_ff <= 16'h0000;
      mvld_ff <= 1'b0;
    end else if (meas_tick) begin
      meas_ff <= start_ff + scl_prod[31:16];
      mvld_ff <= 1'b1;
    end
  end

  vin_flt_if flt ();
  assign flt.raw  = meas_ff;
  assign flt.step = tx_tick;
  assign flt.rate = rate_ff;
  assign flt.span = span;

  vin_ramp u_ramp (
    .clk (CLOCK),
    .rst (RST),
    .f   (flt)
  );

  // ==========================================
  // Operating and error modes
  logic [15:0] sim_val;
  logic [15:0] sub_val;
  logic [15:0] cur_val;
  logic [15:0] lastv_ff;
  logic [15:0] sel_val;
  logic        sub_used;
  logic        fault;
  assign fault   = MEAS_FAULT;
  assign sim_val = pct_to_val(sim_ff, start_ff, span);
  assign sub_val = pct_to_val(subst_ff, start_ff, span);
  assign cur_val = sim_mode ? sim_val : flt.filt;

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      lastv_ff <= 16'h0000;
    end else if (!fault) begin
      lastv_ff <= cur_val;
    end
  end

  always_comb begin
    sel_val  = cur_val;
    sub_used = 1'b0;
    if (fault) begin
      case (err_mode)
        vin_pkg::ERR_CUR: sel_val = cur_val;
        vin_pkg::ERR_SUB: begin
          sel_val  = sub_val;
          sub_used = 1'b1;
        end
        vin_pkg::ERR_LAST: sel_val = lastv_ff;
        default: sel_val = cur_val;
      endcase
    end
  end

  // ==========================================
  // Telegram
  logic            sts_en;
  logic [3:0]      nib;
  logic [15:0]     word_ff;
  vin_pkg::vin_tx_e tx_ff;
  assign sts_en = sts_req && start_ff == vin_pkg::START_DEF
                  && end_ff == vin_pkg::END_DEF;
  assign nib    = sts_en ? {1'b0, sub_used, sim_mode, fault} : 4'h0;

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      word_ff <= 16'h0000;
    end else if (tx_tick) begin
      word_ff <= {sel_val[15:4], nib};
    end
  end

  // Tick may not land mid-frame: period is far longer than 3 cycles
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      tx_ff    <= vin_pkg::TX_IDLE;
      TX_BYTE  <= 8'h00;
      TX_VALID <= 1'b0;
      TX_FIRST <= 1'b0;
    end else begin
      case (tx_ff)
        vin_pkg::TX_IDLE: begin
          TX_VALID <= 1'b0;
          TX_FIRST <= 1'b0;
          if (tx_tick) begin
            tx_ff <= vin_pkg::TX_LO;
          end
        end
        vin_pkg::TX_LO: begin
          TX_BYTE  <= word_ff[7:0];
          TX_VALID <= 1'b1;
          TX_FIRST <= 1'b1;
          tx_ff    <= vin_pkg::TX_HI;
        end
        vin_pkg::TX_HI: begin
          TX_BYTE  <= word_ff[15:8];
          TX_VALID <= 1'b1;
          TX_FIRST <= 1'b0;
          tx_ff    <= vin_pkg::TX_IDLE;
        end
        default: begin
          tx_ff    <= vin_pkg::TX_IDLE;
          TX_VALID <= 1'b0;
          TX_FIRST <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================
  // Identity and error flags
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      CFG_CODE      <= vin_pkg::CFG_CODE_V;
      CFG_IN_BYTES  <= vin_pkg::IN_BYTES;
      CFG_OUT_BYTES <= vin_pkg::OUT_BYTES;
      LEAD_BREAK    <= 1'b0;
      SHORT_CIRC    <= 1'b0;
    end else begin
      CFG_CODE      <= vin_pkg::CFG_CODE_V;
      CFG_IN_BYTES  <= vin_pkg::IN_BYTES;
      CFG_OUT_BYTES <= vin_pkg::OUT_BYTES;
      LEAD_BREAK    <= 1'b0;
      SHORT_CIRC    <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      MOD_ERR  <= 1'b0;
      GLOB_ERR <= 1'b0;
    end else begin
      MOD_ERR  <= fault && rep_en;
      GLOB_ERR <= fault && rep_en;
    end
  end

  // ==========================================
  // Read port
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      REG_RDATA <= 16'h0000;
    end else if (REG_RD) begin
      case (REG_ADDR)
        vin_pkg::A_CTRL:  REG_RDATA <= {10'h000, ctrl_ff};
        vin_pkg::A_START: REG_RDATA <= start_ff;
        vin_pkg::A_END:   REG_RDATA <= end_ff;
        vin_pkg::A_SUBST: REG_RDATA <= subst_ff;
        vin_pkg::A_SIM:   REG_RDATA <= sim_ff;
        vin_pkg::A_RAMP:  REG_RDATA <= {8'h00, rate_ff};
        vin_pkg::A_STAT:  REG_RDATA <= {11'h000, mvld_ff, SHORT_CIRC,
                                        LEAD_BREAK, MOD_ERR, fault};
        vin_pkg::A_VALUE: REG_RDATA <= word_ff;
        vin_pkg::A_CFG:   REG_RDATA <= {CFG_OUT_BYTES, CFG_IN_BYTES, CFG_CODE};
        default:          REG_RDATA <= 16'h0000;
      endcase
    end else begin
      REG_RDATA <= 16'h0000;
    end
  end

  // ==========================================
  // Checks
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  logic [vin_pkg::TMR_W-1:0] gap_ff;
  logic                      seen_ff;
  logic [11:0]               sim_hi;
  logic [11:0]               sub_hi;
  logic [11:0]               last_hi;
  assign sim_hi  = sim_val[15:4];
  assign sub_hi  = sub_val[15:4];
  assign last_hi = lastv_ff[15:4];

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      gap_ff  <= '0;
      seen_ff <= 1'b0;
    end else if (TX_VALID && TX_FIRST) begin
      gap_ff  <= '0;
      seen_ff <= 1'b1;
    end else begin
      gap_ff <= gap_ff + vin_pkg::TMR_ONE;
    end
  end

  sequence seq_lo_hi;
    TX_VALID && TX_FIRST ##1 TX_VALID && !TX_FIRST ##1 !TX_VALID;
  endsequence

  tx_order_a: assert property (tx_tick |-> ##2 seq_lo_hi)
    else $error("telegram byte order broken");
  tx_bytes_a: assert property (tx_tick |-> ##2 TX_BYTE == word_ff[7:0]
    ##1 TX_BYTE == word_ff[15:8])
    else $error("telegram bytes differ from word");
  tx_period_a: assert property (TX_VALID && TX_FIRST && seen_ff
    |-> gap_ff == vin_pkg::TMR_W'(TX_CYC - 1))
    else $error("telegram period wrong");
  low_nib_a: assert property (tx_tick && !sts_en |=> word_ff[3:0] == 4'h0)
    else $error("low nibble not zero");
  cfg_code_a: assert property (CFG_CODE == 8'h32 && CFG_IN_BYTES == 4'h2
    && CFG_OUT_BYTES == 4'h0)
    else $error("configuration code wrong");
  no_line_a: assert property (!LEAD_BREAK && !SHORT_CIRC)
    else $error("line fault raised");
  mod_err_a: assert property (fault && rep_en |=> MOD_ERR && GLOB_ERR)
    else $error("module error not flagged");
  sim_sel_a: assert property (tx_tick && sim_mode && !fault
    |=> word_ff[15:4] == $past(sim_hi))
    else $error("simulation value not sent");
  subst_a: assert property (tx_tick && fault && err_mode == vin_pkg::ERR_SUB
    |=> word_ff[15:4] == $past(sub_hi))
    else $error("substitute value not sent");
  last_val_a: assert property (tx_tick && fault && err_mode == vin_pkg::ERR_LAST
    |=> word_ff[15:4] == $past(last_hi))
    else $error("last valid value not held");
endmodule
`default_nettype wire

/* core/vin_end.sv */
// Purpose: Reserved slot, holds no logic
// Assumes: Nothing
// Notes:   Kept empty on purpose
`default_nettype none
`default_nettype wire

/* tb/vin_com_unit.sv */
// Purpose: Receiving side of the telegram link, the communication unit
// Assumes: Bytes arrive on CLOCK, low byte flagged by first
// Notes:   Counts protocol faults instead of stopping the run
`default_nettype none
module vin_com_unit #(
  parameter int unsigned TX_CYC = 100
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  tx_byte,
  input  wire logic        tx_valid,
  input  wire logic        tx_first,
  input  wire logic [7:0]  cfg_code,
  input  wire logic [3:0]  cfg_in,
  input  wire logic [3:0]  cfg_out,
  output var  logic [15:0] word,
  output var  int unsigned count,
  output var  int unsigned bad
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  lo_ff;
  logic        want_hi_ff;
  logic        seen_ff;
  int unsigned gap_ff;
  // ==========================================
  // Telegram capture
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lo_ff      <= 8'h00;
      want_hi_ff <= 1'b0;
      seen_ff    <= 1'b0;
      gap_ff     <= 0;
      word       <= 16'h0000;
      count      <= 0;
      bad        <= 0;
    end else begin
      gap_ff <= gap_ff + 1;
      if (tx_valid === 1'b1 && tx_first === 1'b1) begin
        lo_ff      <= tx_byte;
        want_hi_ff <= 1'b1;
        seen_ff    <= 1'b1;
        gap_ff     <= 1;
        // A configuration mismatch counts as a fault; the word is still captured
        if (cfg_code !== 8'h32 || cfg_in !== 4'h2 || cfg_out !== 4'h0) bad <= bad + 1;
        if (seen_ff && gap_ff != TX_CYC) bad <= bad + 1;
      end else if (want_hi_ff) begin
        want_hi_ff <= 1'b0;
        if (tx_valid === 1'b1) begin
          word  <= {tx_byte, lo_ff};
          count <= count + 1;
        end else begin
          bad <= bad + 1;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* tb/tb.sv */
// Purpose: Self-checking bench for the voltage input telegram block
// Assumes: Shortened timer parameters, expectations derived from them
// Notes:   Waits span several telegrams so averaging has settled
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned TXC = 100;
  logic        CLOCK = 1'b0;
  logic        RST   = 1'b1;
  logic [5:0]  REG_ADDR = 6'h00;
  logic [15:0] REG_WDATA = 16'h0000;
  logic        REG_WR = 1'b0;
  logic        REG_RD = 1'b0;
  logic [15:0] REG_RDATA;
  logic [15:0] ADC_DATA = 16'h8000;
  logic        MEAS_FAULT = 1'b0;
  logic [7:0]  TX_BYTE;
  logic        TX_VALID;
  logic        TX_FIRST;
  logic [7:0]  CFG_CODE;
  logic [3:0]  CFG_IN_BYTES;
  logic [3:0]  CFG_OUT_BYTES;
  logic        MOD_ERR;
  logic        GLOB_ERR;
  logic        LEAD_BREAK;
  logic        SHORT_CIRC;
  logic [15:0] com_word;
  int unsigned com_count;
  int unsigned com_bad;
  int          err_total = 0;
  int          checks = 0;
  logic [15:0] rv;
  logic [5:0]  ra [8] = '{6'h00, 6'h04, 6'h08, 6'h0C, 6'h10, 6'h14, 6'h20, 6'h3C};
  logic [15:0] re [8] = '{16'h0000, 16'h2710, 16'hC350, 16'h0000, 16'h0000, 16'h0000,
                          16'h0232, 16'h0000};
  vin_top #(.MEAS_CYC(200), .TX_CYC(TXC), .M50_CYC(8), .M60_CYC(6)) vin_top_inst (
    .CLOCK(CLOCK), .RST(RST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .ADC_DATA(ADC_DATA),
    .MEAS_FAULT(MEAS_FAULT), .TX_BYTE(TX_BYTE), .TX_VALID(TX_VALID),
    .TX_FIRST(TX_FIRST), .CFG_CODE(CFG_CODE), .CFG_IN_BYTES(CFG_IN_BYTES),
    .CFG_OUT_BYTES(CFG_OUT_BYTES), .MOD_ERR(MOD_ERR), .GLOB_ERR(GLOB_ERR),
    .LEAD_BREAK(LEAD_BREAK), .SHORT_CIRC(SHORT_CIRC));
  vin_com_unit #(.TX_CYC(TXC)) vin_com_unit_inst (
    .clk(CLOCK), .rst(RST), .tx_byte(TX_BYTE), .tx_valid(TX_VALID),
    .tx_first(TX_FIRST), .cfg_code(CFG_CODE), .cfg_in(CFG_IN_BYTES),
    .cfg_out(CFG_OUT_BYTES), .word(com_word), .count(com_count), .bad(com_bad));
  initial begin
    forever #10 CLOCK = ~CLOCK;
  end
  // ==========================================
  // Access and compare tasks
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge CLOCK);
    REG_ADDR  <= a;
    REG_WDATA <= d;
    REG_WR    <= 1'b1;
    @(posedge CLOCK);
    REG_WR <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, output logic [15:0] d);
    @(posedge CLOCK);
    REG_ADDR <= a;
    REG_RD   <= 1'b1;
    @(posedge CLOCK);
    REG_RD <= 1'b0;
    #1;
    d = REG_RDATA;
  endtask
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: flag %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic wait_tg(input int n);
    int unsigned start;
    int          i;
    start = com_count;
    for (i = 0; i < n * TXC + 50; i++) begin
      @(posedge CLOCK);
      if (com_count >= start + n) break;
    end
    if (com_count < start + n) begin
      err_total++;
      $display("mismatch at %0t: telegrams %h expected %h", $time, com_count, start + n);
      conclude();
    end
  endtask
  // Long wait: eight telegram periods, more than averaging window plus one measurement period
  task automatic tg(input logic [15:0] exp);
    wait_tg(8);
    #1;
    chk16(com_word, exp);
    rd(vin_pkg::A_VALUE, rv);
    chk16(rv, exp);
  endtask
  // ==========================================
  // Main sequence
  initial begin
    repeat (16) @(posedge CLOCK);
    RST <= 1'b0;
    for (int k = 0; k < 8; k++) begin
      rd(ra[k], rv);
      chk16(rv, re[k]);
    end
    wr(vin_pkg::A_CFG, 16'hFFFF);
    rd(vin_pkg::A_CFG, rv);
    chk16(rv, 16'h0232);
    chk16({8'h00, CFG_CODE}, 16'h0032);
    chkb(LEAD_BREAK, 1'b0);
    chkb(SHORT_CIRC, 1'b0);
    $display("test reset_map done");
    tg(16'h7530);
    ADC_DATA <= 16'hFFFF;
    wr(vin_pkg::A_CTRL, 16'h0010);
    tg(16'hC340);
    $display("test normal done");
    wr(vin_pkg::A_SIM, 16'h4E20);
    wr(vin_pkg::A_CTRL, 16'h0009);
    tg(16'hEA62);
    wr(vin_pkg::A_START, 16'h0000);
    tg(16'hF420);
    wr(vin_pkg::A_START, 16'h2710);
    $display("test simulation done");
    wr(vin_pkg::A_SIM, 16'h2710);
    wr(vin_pkg::A_CTRL, 16'h0021);
    MEAS_FAULT <= 1'b1;
    tg(16'hC350);
    chkb(MOD_ERR, 1'b1);
    chkb(GLOB_ERR, 1'b1);
    rd(vin_pkg::A_STAT, rv);
    chk16(rv, 16'h0013);
    wr(vin_pkg::A_CTRL, 16'h0023);
    tg(16'h2710);
    MEAS_FAULT <= 1'b0;
    wr(vin_pkg::A_CTRL, 16'h0005);
    tg(16'hC350);
    MEAS_FAULT <= 1'b1;
    wr(vin_pkg::A_SIM, 16'h0000);
    tg(16'hC350);
    chkb(MOD_ERR, 1'b0);
    MEAS_FAULT <= 1'b0;
    tg(16'h2710);
    $display("test error_modes done");
    ADC_DATA <= 16'h0000;
    wr(vin_pkg::A_CTRL, 16'h0000);
    tg(16'h2710);
    wr(vin_pkg::A_RAMP, 16'h0064);
    ADC_DATA <= 16'hFFFF;
    wait_tg(4);
    #1;
    // Ramp moves no more than about 260 counts per telegram
    chkb(com_word > 16'h2710 && com_word < 16'h2F40, 1'b1);
    rd(vin_pkg::A_RAMP, rv);
    chk16(rv, 16'h0064);
    chk16(com_bad[15:0], 16'h0000);
    $display("test ramp done");
    conclude();
  end
endmodule
`default_nettype wire
